// ==== acm_pkg.sv ====
package acm_pkg;

  // clock and boot timing
  localparam int CLK_MHZ         = 100;
  localparam int BOOT_TIME_US    = 10;
  localparam int BOOT_CYCLES     = BOOT_TIME_US * CLK_MHZ;
  localparam int BOOT_CNT_W      = 11;
  localparam logic [BOOT_CNT_W-1:0] BOOT_LAST = BOOT_CNT_W'(BOOT_CYCLES - 1);

  // serial frame layout: rw, address, three spare bits, data byte
  localparam int FRAME_BITS      = 16;
  localparam int FRAME_RW_BIT    = 15;
  localparam int FRAME_ADDR_MSB  = 14;
  localparam int FRAME_ADDR_LSB  = 11;
  localparam int FRAME_DATA_MSB  = 7;
  localparam logic [3:0] BIT_LAST    = 4'hF;
  localparam logic [3:0] BIT_TX_LOAD = 4'h8;

  // register addresses
  localparam logic [3:0] ADDR_CTRL      = 4'h0;
  localparam logic [3:0] ADDR_RES_UPPER = 4'h1;
  localparam logic [3:0] ADDR_RES_LOWER = 4'h2;
  localparam logic [3:0] ADDR_RESET_CMD = 4'hF;

  // control register fields
  localparam int CTRL_RDY_BIT    = 7;
  localparam int CTRL_OVF_BIT    = 6;
  localparam int CTRL_CH_MSB     = 6;
  localparam int CTRL_CH_LSB     = 4;
  localparam int CTRL_CH_RD_MSB  = 5;
  localparam int CTRL_MODE_MSB   = 3;

  // reset values
  localparam logic       RDY_N_RST = 1'b1;
  localparam logic       OVF_RST   = 1'b0;
  localparam logic [2:0] CH_RST    = 3'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] RES_RST  = 16'h0000;

  // operation mode codes
  localparam logic [3:0] MODE_IDLE      = 4'h0;
  localparam logic [3:0] MODE_SINGLE    = 4'h2;
  localparam logic [3:0] MODE_CONT      = 4'h3;
  localparam logic [3:0] MODE_SINGLE_PA = 4'h4;
  localparam logic [3:0] MODE_CONT_PA   = 4'h5;
  localparam logic [3:0] MODE_CAL_AOFF  = 4'h8;
  localparam logic [3:0] MODE_CAL_AGAIN = 4'h9;
  localparam logic [3:0] MODE_CAL_POFF  = 4'hA;
  localparam logic [3:0] MODE_CAL_SOFF  = 4'hC;
  localparam logic [3:0] MODE_CAL_SGAIN = 4'hD;
  localparam logic [3:0] MODE_BOOT      = 4'hF;

  // input routing codes
  localparam logic [2:0] CH_POS_NEG  = 3'h0;
  localparam logic [2:0] CH_POS_GND  = 3'h2;
  localparam logic [2:0] CH_NEG_GND  = 3'h3;
  localparam logic [2:0] CH_REF_GND  = 3'h4;
  localparam logic [2:0] CH_GND_GND  = 3'h5;
  localparam logic [2:0] CH_NEG_NEG  = 3'h6;

  // data rate divisors
  localparam logic [1:0] RATE_FULL  = 2'h1;
  localparam logic [1:0] RATE_HALF  = 2'h2;
  localparam logic [1:0] RATE_THIRD = 2'h3;

  typedef enum logic [2:0] {
    ST_BOOT = 3'b001,
    ST_IDLE = 3'b010,
    ST_RUN  = 3'b100
  } acm_state_t;

endpackage : acm_pkg

// ==== acm_tgl_sync.sv ====
module acm_tgl_sync (
  input  wire logic clk,       // destination clock
  input  wire logic rst_n,     // async reset, active low
  input  wire logic tgl_in,    // toggle from the other domain
  output logic      pulse      // one cycle per toggle
);

  logic s1_r, s2_r, s3_r, pulse_r;
  logic s1_nxt, s2_nxt, s3_nxt, pulse_nxt;

  // first stage feeds only the second stage
  always_comb begin
    s1_nxt    = tgl_in;
    s2_nxt    = s1_r;
    s3_nxt    = s2_r;
    pulse_nxt = s2_r ^ s3_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      pulse_r <= 1'b0;
    end else begin
      s1_r    <= s1_nxt;
      s2_r    <= s2_nxt;
      s3_r    <= s3_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign pulse = pulse_r;

endmodule : acm_tgl_sync

// ==== acm_ctrl.sv ====
// Contract
// - write-only bits read zero, read-only ignore writes, read-write bits store.
// - all registers take reset values on power-on and serial reset command.
// - not-ready flag bit 7 clears when a new result is stored.
// - reading the result upper byte sets the not-ready flag again.
// - overflow flag bit 6 sets on overflowed result and on upper byte read.
// - reading the mode field returns the operation currently in effect.
// - channel selector routes inputs per its six defined codes.
// - mode 0x0 holds the converter idle awaiting a command.
// - mode 0x2 converts once with offset, then returns to idle.
// - mode 0x3 converts repeatedly with offset until idle is written.
// - mode 0x4 single alternated conversion, half rate, no offset.
// - mode 0x5 continuous alternated conversion, third rate, no offset.
// - mode 0x8 amp off, gain x1, grounded input, store converter offset.
// - mode 0x9 amp off, gain x1, reference input, store converter gain.
// - mode 0xA keeps gains, negative pin both inputs, store amplifier offset.
// - mode 0xC calibrates system offset on selected channel, stores offset.
// - mode 0xD calibrates system gain on selected channel, stores gain.
// - mode reads 0xF after reset, then turns idle once boot completes.
module acm_ctrl (
  input  wire logic        CLK,            // system clock, 100 MHz
  input  wire logic        RESET_N,        // async reset, active low
  input  wire logic        SCK,            // serial clock from controller
  input  wire logic        SDI,            // serial data in
  output logic             SDO,            // serial data out
  input  wire logic        CONV_DONE,      // converter finished, one-cycle pulse
  input  wire logic [15:0] CONV_DATA,      // result or calibration coefficient
  input  wire logic        CONV_OVF,       // result overflowed
  output logic             CONV_START,     // start one conversion, pulse
  output logic [2:0]       INPUT_ROUTE,    // effective input routing code
  output logic             POLARITY_ALTERNATION_EN,        // polarity alternation on
  output logic [1:0]       RATE_DIV,       // data rate divisor
  output logic             USE_OFFSET,     // apply offset coefficient
  output logic             AMP1_FORCE_OFF, // first amplifier forced off
  output logic             AMP2_FORCE_X1,  // second amplifier forced to x1
  output logic             OFFSET_STORE,   // store coefficient as offset, pulse
  output logic             GAIN_STORE,     // store coefficient as gain, pulse
  output logic             DATA_NOT_READY  // not-ready flag level
);

  // ---------------- link side, on SCK ----------------
  logic [3:0]  bit_cnt_r, bit_cnt_nxt;
  logic [14:0] rx_r, rx_nxt;
  logic [15:0] frame_r, frame_nxt;
  logic        req_tgl_r, req_tgl_nxt;
  logic [7:0]  tx_r, tx_nxt;
  logic        sdo_r, sdo_nxt;
  logic [7:0]  rd_data_r, rd_data_nxt;

  // shift in on rising edge; a full frame flips the request toggle
  always_comb begin
    bit_cnt_nxt = bit_cnt_r + 4'h1;
    rx_nxt      = {rx_r[13:0], SDI};
    frame_nxt   = frame_r;
    req_tgl_nxt = req_tgl_r;
    if (bit_cnt_r == acm_pkg::BIT_LAST) begin
      frame_nxt   = {rx_r, SDI};
      req_tgl_nxt = ~req_tgl_r;
    end
  end

  always_ff @(posedge SCK or negedge RESET_N) begin
    if (!RESET_N) begin
      bit_cnt_r <= 4'h0;
      rx_r      <= 15'h0000;
      frame_r   <= 16'h0000;
      req_tgl_r <= 1'b0;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      rx_r      <= rx_nxt;
      frame_r   <= frame_nxt;
      req_tgl_r <= req_tgl_nxt;
    end
  end

  // read byte goes out in the second half of the next frame;
  // rd_data_r is quiet by then because the controller spaces frames
  always_comb begin
    tx_nxt  = {tx_r[6:0], 1'b0};
    sdo_nxt = 1'b0;
    if (bit_cnt_r == acm_pkg::BIT_TX_LOAD) begin
      sdo_nxt = rd_data_r[acm_pkg::FRAME_DATA_MSB];
      tx_nxt  = {rd_data_r[6:0], 1'b0};
    end else if (bit_cnt_r > acm_pkg::BIT_TX_LOAD) begin
      sdo_nxt = tx_r[acm_pkg::FRAME_DATA_MSB];
    end
  end

  always_ff @(negedge SCK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_r  <= 8'h00;
      sdo_r <= 1'b0;
    end else begin
      tx_r  <= tx_nxt;
      sdo_r <= sdo_nxt;
    end
  end

  assign SDO = sdo_r;

  // ---------------- core side, on CLK ----------------
  logic cmd_pulse;

  acm_tgl_sync u_req_sync (
    .clk    (CLK),
    .rst_n  (RESET_N),
    .tgl_in (req_tgl_r),
    .pulse  (cmd_pulse)
  );

  // frame_r is stable long before the toggle lands here
  logic       cmd_rd;
  logic [3:0] cmd_addr;
  logic [7:0] cmd_data;
  assign cmd_rd   = frame_r[acm_pkg::FRAME_RW_BIT];
  assign cmd_addr = frame_r[acm_pkg::FRAME_ADDR_MSB:acm_pkg::FRAME_ADDR_LSB];
  assign cmd_data = frame_r[acm_pkg::FRAME_DATA_MSB:0];

  acm_pkg::acm_state_t state_r, state_nxt;
  logic [3:0]  mode_r, mode_nxt;
  logic [2:0]  input_channel_select_r, input_channel_select_nxt;
  logic        rdy_n_r, rdy_n_nxt;
  logic        ovf_r, ovf_nxt;
  logic [15:0] res_r, res_nxt;
  logic [7:0]  lower_r, lower_nxt;
  logic [acm_pkg::BOOT_CNT_W-1:0] boot_cnt_r, boot_cnt_nxt;
  logic        start_r, start_nxt;
  logic [2:0]  route_r, route_nxt;
  logic        polarity_alternation_r, polarity_alternation_nxt;
  logic [1:0]  rate_r, rate_nxt;
  logic        use_off_r, use_off_nxt;
  logic        amp1_off_r, amp1_off_nxt;
  logic        amp2_x1_r, amp2_x1_nxt;
  logic        off_st_r, off_st_nxt;
  logic        gain_st_r, gain_st_nxt;
  logic        new_res;

  // reserved codes and boot are never taken from a write
  function automatic logic mode_legal(input logic [3:0] code);
    logic ok;
    ok = 1'b0;
    case (code)
      acm_pkg::MODE_IDLE,      acm_pkg::MODE_SINGLE,
      acm_pkg::MODE_CONT,      acm_pkg::MODE_SINGLE_PA,
      acm_pkg::MODE_CONT_PA,   acm_pkg::MODE_CAL_AOFF,
      acm_pkg::MODE_CAL_AGAIN, acm_pkg::MODE_CAL_POFF,
      acm_pkg::MODE_CAL_SOFF,  acm_pkg::MODE_CAL_SGAIN: ok = 1'b1;
      default:                                           ok = 1'b0;
    endcase
    return ok;
  endfunction : mode_legal

  // mode sequencing, result capture and register access
  always_comb begin
    state_nxt    = state_r;
    mode_nxt     = mode_r;
    input_channel_select_nxt    = input_channel_select_r;
    rdy_n_nxt    = rdy_n_r;
    ovf_nxt      = ovf_r;
    res_nxt      = res_r;
    lower_nxt    = lower_r;
    boot_cnt_nxt = boot_cnt_r;
    rd_data_nxt  = rd_data_r;
    start_nxt    = 1'b0;
    off_st_nxt   = 1'b0;
    gain_st_nxt  = 1'b0;
    new_res      = 1'b0;

    case (state_r)
      acm_pkg::ST_BOOT: begin
        if (boot_cnt_r == acm_pkg::BOOT_LAST) begin
          state_nxt = acm_pkg::ST_IDLE;
          mode_nxt  = acm_pkg::MODE_IDLE;
        end else begin
          boot_cnt_nxt = boot_cnt_r + 1'b1;
        end
      end
      acm_pkg::ST_IDLE: begin
        state_nxt = acm_pkg::ST_IDLE;
      end
      acm_pkg::ST_RUN: begin
        if (CONV_DONE) begin
          case (mode_r)
            acm_pkg::MODE_CONT, acm_pkg::MODE_CONT_PA: begin
              res_nxt   = CONV_DATA;
              rdy_n_nxt = 1'b0;
              ovf_nxt   = CONV_OVF;
              new_res   = 1'b1;
              start_nxt = 1'b1;
            end
            acm_pkg::MODE_SINGLE, acm_pkg::MODE_SINGLE_PA: begin
              res_nxt   = CONV_DATA;
              rdy_n_nxt = 1'b0;
              ovf_nxt   = CONV_OVF;
              new_res   = 1'b1;
              state_nxt = acm_pkg::ST_IDLE;
              mode_nxt  = acm_pkg::MODE_IDLE;
            end
            acm_pkg::MODE_CAL_AOFF, acm_pkg::MODE_CAL_POFF, acm_pkg::MODE_CAL_SOFF: begin
              off_st_nxt = 1'b1;
              state_nxt  = acm_pkg::ST_IDLE;
              mode_nxt   = acm_pkg::MODE_IDLE;
            end
            default: begin
              gain_st_nxt = 1'b1;
              state_nxt   = acm_pkg::ST_IDLE;
              mode_nxt    = acm_pkg::MODE_IDLE;
            end
          endcase
        end
      end
      default: begin
        state_nxt = acm_pkg::ST_BOOT;
      end
    endcase

    if (cmd_pulse && cmd_rd) begin
      // reads; set from a fresh result wins over the read side effect
      if (cmd_addr == acm_pkg::ADDR_CTRL) begin
        rd_data_nxt = {rdy_n_r, ovf_r, input_channel_select_r[1:0], mode_r};
      end else if (cmd_addr == acm_pkg::ADDR_RES_UPPER) begin
        rd_data_nxt = res_r[15:8];
        lower_nxt   = res_r[7:0];
        if (!new_res) begin
          rdy_n_nxt = 1'b1;
          ovf_nxt   = 1'b1;
        end
      end else if (cmd_addr == acm_pkg::ADDR_RES_LOWER) begin
        rd_data_nxt = lower_r;
      end else begin
        rd_data_nxt = acm_pkg::BYTE_ZERO;
      end
    end else if (cmd_pulse && cmd_addr == acm_pkg::ADDR_CTRL) begin
      // flags are read-only; channel and mode are stored
      input_channel_select_nxt = cmd_data[acm_pkg::CTRL_CH_MSB:acm_pkg::CTRL_CH_LSB];
      if (state_r != acm_pkg::ST_BOOT && mode_legal(cmd_data[acm_pkg::CTRL_MODE_MSB:0])) begin
        mode_nxt = cmd_data[acm_pkg::CTRL_MODE_MSB:0];
        if (cmd_data[acm_pkg::CTRL_MODE_MSB:0] == acm_pkg::MODE_IDLE) begin
          state_nxt = acm_pkg::ST_IDLE;
          start_nxt = 1'b0;                                         // a result in the same cycle must not restart
        end else begin
          state_nxt = acm_pkg::ST_RUN;
          start_nxt = 1'b1;
        end
      end
    end else if (cmd_pulse && cmd_addr == acm_pkg::ADDR_RESET_CMD) begin
      state_nxt    = acm_pkg::ST_BOOT;
      mode_nxt     = acm_pkg::MODE_BOOT;
      input_channel_select_nxt    = acm_pkg::CH_RST;
      rdy_n_nxt    = acm_pkg::RDY_N_RST;
      ovf_nxt      = acm_pkg::OVF_RST;
      res_nxt      = acm_pkg::RES_RST;
      lower_nxt    = acm_pkg::BYTE_ZERO;
      rd_data_nxt  = acm_pkg::BYTE_ZERO;
      boot_cnt_nxt = '0;
      start_nxt    = 1'b0;
      off_st_nxt   = 1'b0;
      gain_st_nxt  = 1'b0;
    end
  end

  // analog setup follows the mode in effect after this edge
  always_comb begin
    route_nxt    = input_channel_select_nxt;
    polarity_alternation_nxt     = 1'b0;
    rate_nxt     = acm_pkg::RATE_FULL;
    use_off_nxt  = 1'b0;
    amp1_off_nxt = 1'b0;
    amp2_x1_nxt  = 1'b0;
    case (mode_nxt)
      acm_pkg::MODE_SINGLE, acm_pkg::MODE_CONT: begin
        use_off_nxt = 1'b1;
      end
      acm_pkg::MODE_SINGLE_PA: begin
        polarity_alternation_nxt = 1'b1;
        rate_nxt = acm_pkg::RATE_HALF;
      end
      acm_pkg::MODE_CONT_PA: begin
        polarity_alternation_nxt = 1'b1;
        rate_nxt = acm_pkg::RATE_THIRD;
      end
      acm_pkg::MODE_CAL_AOFF: begin
        route_nxt    = acm_pkg::CH_GND_GND;
        amp1_off_nxt = 1'b1;
        amp2_x1_nxt  = 1'b1;
      end
      acm_pkg::MODE_CAL_AGAIN: begin
        route_nxt    = acm_pkg::CH_REF_GND;
        amp1_off_nxt = 1'b1;
        amp2_x1_nxt  = 1'b1;
      end
      acm_pkg::MODE_CAL_POFF: begin
        route_nxt = acm_pkg::CH_NEG_NEG;
      end
      default: begin
        route_nxt = input_channel_select_nxt;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r    <= acm_pkg::ST_BOOT;
      mode_r     <= acm_pkg::MODE_BOOT;
      input_channel_select_r    <= acm_pkg::CH_RST;
      rdy_n_r    <= acm_pkg::RDY_N_RST;
      ovf_r      <= acm_pkg::OVF_RST;
      res_r      <= acm_pkg::RES_RST;
      lower_r    <= acm_pkg::BYTE_ZERO;
      boot_cnt_r <= '0;
      rd_data_r  <= acm_pkg::BYTE_ZERO;
      start_r    <= 1'b0;
      route_r    <= acm_pkg::CH_RST;
      polarity_alternation_r     <= 1'b0;
      rate_r     <= acm_pkg::RATE_FULL;
      use_off_r  <= 1'b0;
      amp1_off_r <= 1'b0;
      amp2_x1_r  <= 1'b0;
      off_st_r   <= 1'b0;
      gain_st_r  <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      mode_r     <= mode_nxt;
      input_channel_select_r    <= input_channel_select_nxt;
      rdy_n_r    <= rdy_n_nxt;
      ovf_r      <= ovf_nxt;
      res_r      <= res_nxt;
      lower_r    <= lower_nxt;
      boot_cnt_r <= boot_cnt_nxt;
      rd_data_r  <= rd_data_nxt;
      start_r    <= start_nxt;
      route_r    <= route_nxt;
      polarity_alternation_r     <= polarity_alternation_nxt;
      rate_r     <= rate_nxt;
      use_off_r  <= use_off_nxt;
      amp1_off_r <= amp1_off_nxt;
      amp2_x1_r  <= amp2_x1_nxt;
      off_st_r   <= off_st_nxt;
      gain_st_r  <= gain_st_nxt;
    end
  end

  // all outputs straight from flops
  assign CONV_START     = start_r;
  assign INPUT_ROUTE    = route_r;
  assign POLARITY_ALTERNATION_EN        = polarity_alternation_r;
  assign RATE_DIV       = rate_r;
  assign USE_OFFSET     = use_off_r;
  assign AMP1_FORCE_OFF = amp1_off_r;
  assign AMP2_FORCE_X1  = amp2_x1_r;
  assign OFFSET_STORE   = off_st_r;
  assign GAIN_STORE     = gain_st_r;
  assign DATA_NOT_READY = rdy_n_r;

endmodule : acm_ctrl

// ==== acm_ctrl_sva.sv ====
module acm_ctrl_sva (
  input wire logic       CLK,            // system clock
  input wire logic       RESET_N,        // async reset, active low
  input wire logic       CONV_DONE,      // converter finished
  input wire logic       CONV_START,     // conversion start pulse
  input wire logic [2:0] INPUT_ROUTE,    // effective routing
  input wire logic       POLARITY_ALTERNATION_EN,        // alternation on
  input wire logic [1:0] RATE_DIV,       // rate divisor
  input wire logic       USE_OFFSET,     // offset applied
  input wire logic       AMP1_FORCE_OFF, // first amp off
  input wire logic       AMP2_FORCE_X1,  // second amp x1
  input wire logic       OFFSET_STORE,   // offset store pulse
  input wire logic       GAIN_STORE,     // gain store pulse
  input wire logic       DATA_NOT_READY  // not-ready level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [10:0] boot_cnt_r;
  logic [10:0] boot_cnt_nxt;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  // cycles since reset, saturating so it never wraps into the boot window
  always_comb begin
    boot_cnt_nxt = boot_cnt_r;
    if (boot_cnt_r != 11'(acm_pkg::BOOT_CYCLES)) boot_cnt_nxt = boot_cnt_r + 11'h001;
  end

  // counter register
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) boot_cnt_r <= 11'h000;
    else boot_cnt_r <= boot_cnt_nxt;
  end

  a_start_pulse: assert property (CONV_START |=> !CONV_START) else $error("start too long");
  a_boot_quiet: assert property (CONV_START |-> boot_cnt_r == 11'(acm_pkg::BOOT_CYCLES))
    else $error("start during boot");
  a_ready_on_result: assert property ((CONV_DONE && (USE_OFFSET || POLARITY_ALTERNATION_EN)) |=> !DATA_NOT_READY)
    else $error("ready flag not cleared");
  a_offset_rate: assert property (USE_OFFSET |-> !POLARITY_ALTERNATION_EN && RATE_DIV == acm_pkg::RATE_FULL)
    else $error("offset mode with wrong rate");
  a_polarity_alternation_rate: assert property (POLARITY_ALTERNATION_EN |-> !USE_OFFSET && RATE_DIV inside {2'h2, 2'h3})
    else $error("alternation with wrong rate");
  a_third_polarity_alternation: assert property (RATE_DIV == acm_pkg::RATE_THIRD |-> POLARITY_ALTERNATION_EN)
    else $error("third rate without alternation");
  a_amp_forced: assert property (AMP1_FORCE_OFF |-> AMP2_FORCE_X1 && INPUT_ROUTE inside {3'h4, 3'h5})
    else $error("amp forcing inconsistent");
  a_store_cause: assert property ((OFFSET_STORE || GAIN_STORE) |-> $past(CONV_DONE))
    else $error("store without completion");
  a_store_single: assert property (OFFSET_STORE |-> !GAIN_STORE ##1 !OFFSET_STORE)
    else $error("store pulse malformed");
endmodule : acm_ctrl_sva

bind acm_ctrl acm_ctrl_sva i_sva (
  .CLK(CLK), .RESET_N(RESET_N), .CONV_DONE(CONV_DONE), .CONV_START(CONV_START),
  .INPUT_ROUTE(INPUT_ROUTE), .POLARITY_ALTERNATION_EN(POLARITY_ALTERNATION_EN), .RATE_DIV(RATE_DIV), .USE_OFFSET(USE_OFFSET),
  .AMP1_FORCE_OFF(AMP1_FORCE_OFF), .AMP2_FORCE_X1(AMP2_FORCE_X1), .OFFSET_STORE(OFFSET_STORE),
  .GAIN_STORE(GAIN_STORE), .DATA_NOT_READY(DATA_NOT_READY));

// ==== acm_spi_host.sv ====
module acm_spi_host (
  output logic        sck,  // link clock, still between frames
  output logic        sdi,  // data to device
  input  wire logic   sdo,  // data from device
  input  wire logic   go,   // rising edge starts a frame
  input  wire logic [15:0] tx, // frame to send
  output logic        busy, // frame or gap in progress
  output logic [15:0] rx    // bits seen on sdo
);
  timeunit 1ns;
  timeprecision 100ps;

  // 15 ns link clock runs only inside a frame, msb first
  initial begin
    sck = 1'b0;
    sdi = 1'b0;
    busy = 1'b0;
    rx = 16'h0000;
    forever begin
      @(posedge go);
      busy = 1'b1;
      for (int i = 15; i >= 0; i--) begin
        sdi = tx[i];
        #7.5 sck = 1'b1;
        rx = {rx[14:0], sdo};
        #7.5 sck = 1'b0;
      end
      sdi = ~tx[0]; // idle line must not look like a held bit
      #150 busy = 1'b0; // gap keeps the pending answer valid
    end
  end
endmodule : acm_spi_host

// ==== acm_ctrl_tb_top.sv ====
`define CHK(nm, ex, ac) \
  begin \
    samples_checked++; \
    if ((ac) !== (ex)) begin \
      bad_count++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, ac); \
    end \
  end

module acm_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, reset_n, sck, sdi, sdo, go, busy, kick;
  logic        conv_done, conv_ovf, conv_start, polarity_alternation_en, use_offset;
  logic        amp1_off, amp2_x1, offset_store, gain_store, not_ready;
  logic [15:0] conv_data, tx, rx;
  logic [2:0]  input_route;
  logic [1:0]  rate_div;
  logic [8:0]  snap;
  int          cnt, starts, n_off, n_gain, cycles, bad_count, samples_checked;

  acm_ctrl i_dut (.CLK(clk), .RESET_N(reset_n), .SCK(sck), .SDI(sdi), .SDO(sdo),
    .CONV_DONE(conv_done), .CONV_DATA(conv_data), .CONV_OVF(conv_ovf), .CONV_START(conv_start),
    .INPUT_ROUTE(input_route), .POLARITY_ALTERNATION_EN(polarity_alternation_en), .RATE_DIV(rate_div), .USE_OFFSET(use_offset),
    .AMP1_FORCE_OFF(amp1_off), .AMP2_FORCE_X1(amp2_x1), .OFFSET_STORE(offset_store),
    .GAIN_STORE(gain_store), .DATA_NOT_READY(not_ready));
  acm_spi_host i_host (.sck(sck), .sdi(sdi), .sdo(sdo), .go(go), .tx(tx), .busy(busy), .rx(rx));

  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  // converter stand-in: answers a start or kick after 20 cycles, tallies pulses
  always @(negedge clk) begin
    conv_done <= (cnt == 1);
    if (conv_start) starts <= starts + 1;
    if (offset_store) n_off <= n_off + 1;
    if (gain_store) n_gain <= n_gain + 1;
    if (cnt == 10) snap <= {input_route, polarity_alternation_en, rate_div, use_offset, amp1_off, amp2_x1};
    if (cnt != 0) cnt <= cnt - 1;
    else if (conv_start || kick) cnt <= 20;
  end

  task automatic wrap_up();
    if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  task automatic xfer(input logic [15:0] f);
    @(negedge clk) tx = f;
    go = 1'b1;
    @(negedge clk) go = 1'b0;
    wait (!busy);
  endtask : xfer

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    xfer({1'b0, a, 3'h0, d});
  endtask : wr

  // answer arrives in the following frame, so a harmless control read follows
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    xfer({1'b1, a, 11'h000});
    xfer(16'h8000);
    d = rx[7:0];
  endtask : rd

  task automatic t_boot();
    logic [7:0] d;
    wr(4'h0, 8'h22);
    rd(4'h0, d);
    `CHK("boot ctrl", 8'hAF, d)
    repeat (1000) @(negedge clk);
    rd(4'h0, d);
    `CHK("idle ctrl", 8'hA0, d)
    `CHK("boot starts", 0, starts)
  endtask : t_boot

  task automatic t_route();
    logic [2:0] chs [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    foreach (chs[i]) begin
      wr(4'h0, {1'b0, chs[i], 4'h0});
      repeat (10) @(negedge clk);
      `CHK("route", chs[i], input_route)
    end
  endtask : t_route

  task automatic t_conv(input logic [3:0] m, input bit cont, input logic ov, input logic [15:0] v,
                        input logic [8:0] e);
    logic [7:0] d;
    int s0, s1;
    @(negedge clk) conv_data = v;
    conv_ovf = ov;
    s0 = starts;
    wr(4'h0, {4'h3, m});
    repeat (40) @(negedge clk);
    `CHK("run outputs", e, snap)
    if (cont) begin
      `CHK("restarts", 1'b1, (starts - s0) >= 2)
      rd(4'h0, d);
      `CHK("running mode", m, d[3:0])
      wr(4'h0, 8'h30);
      repeat (30) @(negedge clk);
      s1 = starts;
      repeat (60) @(negedge clk);
      `CHK("stopped", s1, starts)
    end else begin
      `CHK("one start", 1, starts - s0)
      `CHK("ready pin", 1'b0, not_ready)
      rd(4'h0, d);
      `CHK("done ctrl", {1'b0, ov, 6'h30}, d)
      rd(4'h1, d);
      `CHK("upper", v[15:8], d)
      rd(4'h2, d);
      `CHK("lower", v[7:0], d)
      rd(4'h0, d);
      `CHK("after upper", 8'hF0, d)
    end
  endtask : t_conv

  task automatic t_cal(input logic [3:0] m, input logic [8:0] e, input int eo, input int eg);
    logic [7:0] d;
    int o0, g0;
    o0 = n_off;
    g0 = n_gain;
    wr(4'h0, {4'h2, m});
    @(posedge clk) kick = 1'b1;
    @(posedge clk) kick = 1'b0;
    repeat (50) @(negedge clk);
    `CHK("cal outputs", e, snap)
    `CHK("offset stores", eo, n_off - o0)
    `CHK("gain stores", eg, n_gain - g0)
    rd(4'h0, d);
    `CHK("cal end mode", 4'h0, d[3:0])
  endtask : t_cal

  task automatic t_misc();
    logic [7:0] d;
    wr(4'h3, 8'h5A);
    rd(4'h3, d);
    `CHK("unmapped", 8'h00, d)
    wr(4'hF, 8'h00);
    rd(4'h0, d);
    `CHK("serial reset", 8'h8F, d)
    repeat (1000) @(negedge clk);
    rd(4'h0, d);
    `CHK("reboot idle", 8'h80, d)
  endtask : t_misc

  // main sequence
  initial begin
    reset_n = 1'b0;
    {go, kick, conv_done, conv_ovf, tx, conv_data, snap} = '0;
    {cnt, starts, n_off, n_gain, cycles, bad_count, samples_checked} = '0;
    repeat (4) @(negedge clk);
    `CHK("reset rate", 2'h1, rate_div)
    `CHK("reset ready", 1'b1, not_ready)
    reset_n = 1'b1;
    t_boot();
    t_route();
    t_conv(4'h2, 0, 1'b0, 16'h8000, 9'b011_0_01_1_00);
    t_conv(4'h4, 0, 1'b1, 16'h7FFF, 9'b011_1_10_0_00);
    t_conv(4'h3, 1, 1'b0, 16'h1234, 9'b011_0_01_1_00);
    t_conv(4'h5, 1, 1'b0, 16'h1234, 9'b011_1_11_0_00);
    t_cal(4'h8, 9'b101_0_01_0_11, 1, 0);
    t_cal(4'h9, 9'b100_0_01_0_11, 0, 1);
    t_cal(4'hA, 9'b110_0_01_0_00, 1, 0);
    t_cal(4'hC, 9'b010_0_01_0_00, 1, 0);
    t_cal(4'hD, 9'b010_0_01_0_00, 0, 1);
    t_misc();
    wrap_up();
  end
endmodule : acm_ctrl_tb_top
